// ---- core/lefh_consts.svh ----
`ifndef LEFH_CONSTS_SVH
`define LEFH_CONSTS_SVH

// register offsets
`define LEFH_ADDR_W 5
`define LEFH_OFS_INT_CTRL 5'h02
`define LEFH_OFS_EVENT_MASK 5'h03
`define LEFH_OFS_EVENT_FLAGS 5'h04
`define LEFH_OFS_HOOK_CTRL 5'h05
`define LEFH_OFS_POWER_CTRL 5'h06
`define LEFH_OFS_LINE_STATUS 5'h0c
`define LEFH_OFS_RING_OPT 5'h10
`define LEFH_OFS_RX_STATUS 5'h11
`define LEFH_OFS_SUPPLY_STATUS 5'h13
`define LEFH_OFS_EVENT_CLEAR 5'h1e

// event flag bits
`define LEFH_EV_RING 7
`define LEFH_EV_RX_OVL 6
`define LEFH_EV_FRAME 5
`define LEFH_EV_BILLING 4
`define LEFH_EV_DROPOUT 3
`define LEFH_EV_LOOP_OVL 2
`define LEFH_EV_TIP_GND 1
`define LEFH_EV_POLARITY 0

// control bits
`define LEFH_BIT_GLOBAL_INTERRUPT_ENABLE 7
`define LEFH_BIT_RING_MODE 2
`define LEFH_BIT_NEG_RING 6
`define LEFH_BIT_POS_RING 5
`define LEFH_BIT_ONHOOK_MON 3
`define LEFH_BIT_RING_STATUS 2
`define LEFH_BIT_OFFHOOK 0
`define LEFH_BIT_POWERDOWN 4
`define LEFH_BIT_FULL_WAVE 0
`define LEFH_BIT_FRAME_LOCK 6
`define LEFH_BIT_RX_OVL 0
`define LEFH_BIT_DROPOUT 1
`define LEFH_BIT_OVERCURRENT 0

// reset value and loop current maximum
`define LEFH_RST_POWERDOWN 1'h1
`define LEFH_LOOP_MAX 5'h1f

// timing
`define LEFH_CLK_HZ 25000000
`define LEFH_RING_HOLD_MS 5000
`define LEFH_RING_HOLD_CYCLES (`LEFH_RING_HOLD_MS * (`LEFH_CLK_HZ / 1000))

`endif

// ---- core/lefh_pkg.sv ----
package lefh_pkg;

  typedef logic [26:0] lefh_cnt_type;

  // synchronised line-side inputs
  typedef struct packed {
    logic ring_pos;
    logic ring_neg;
    logic rx_ovl;
    logic frame_lock;
    logic billing;
    logic dropout;
    logic overcurrent;
    logic tip_gnd_status;
    logic lvs_msb;
    logic [4:0] loop_current;
  } lefh_line_type;

  typedef struct packed {
    lefh_line_type sync1;
    lefh_line_type sync2;
    logic [1:0] warm;
    logic lvs_prev;
    logic ring_prev;
    logic [7:0] flags;
    logic [7:0] mask;
    logic global_interrupt_enable;
    logic ring_mode;
    logic offhook;
    logic onhook_mon;
    logic powerdown;
    logic full_wave;
    logic ring_status;
    lefh_cnt_type ring_cnt;
    logic [7:0] rdata;
    logic irq;
  } lefh_state_type;

endpackage : lefh_pkg

// ---- core/lefh_line_event_flags.sv ----
//
// Functional notes
// - ring sets flag bit 7; irq when ring mask and global enable set
// - flags sticky until host writes 0, or writes 1 to the event clear register
// - ring burst mode: flag at burst start only, or start and end
// - bit 6 set on rx overload; mirrors rx status, clear clears both
// - bit 5 set while frame lock missing; a host clear holds only once lock is back
// - bit 4 set on billing tone; drives irq when enabled
// - bit 3 set when line supply collapses, with dropout status
// - bit 2 set when loop current field reaches maximum
// - bit 1 set when tip grounded; inverse of tip ground status
// - bit 0 set on any change of line voltage msb once the synchroniser is full
// - control bits 6 and 5 show negative and positive ring now
// - control bit 3 enables on-hook monitoring mode
// - ring status high during ring; clears 5 s later or off-hook
// - full-wave option 0: positive rings only; 1: either polarity
// - control bit 0 commands off-hook; 0 returns on-hook
// - dual mode end event only when start flag was cleared first
//
`timescale 1ns/1ps
`default_nettype none
`include "lefh_consts.svh"

module lefh_line_event_flags
  import lefh_pkg::*;
#(
  parameter int unsigned RING_HOLD_CYCLES = `LEFH_RING_HOLD_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [`LEFH_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_ring_pos,
  input wire logic i_ring_neg,
  input wire logic i_rx_overload,
  input wire logic i_frame_lock,
  input wire logic i_billing_tone,
  input wire logic i_supply_dropout,
  input wire logic i_overcurrent,
  input wire logic i_tip_ground_status,
  input wire logic i_line_voltage_msb,
  input wire logic [4:0] i_loop_current,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_offhook,
  output logic o_onhook_monitor,
  output logic o_line_powerdown
);

  ////////////////////////////////////////////////////////////////////////////
  localparam lefh_cnt_type HOLD = lefh_cnt_type'(RING_HOLD_CYCLES);

  lefh_state_type st;
  lefh_state_type next_st;
  lefh_line_type line_in;
  lefh_line_type ln;
  logic [7:0] set_ev;
  logic [7:0] clr_ev;
  logic ring_hit;
  logic ring_now;
  logic [7:0] rd_val;

  assign line_in = '{
    ring_pos: i_ring_pos,
    ring_neg: i_ring_neg,
    rx_ovl: i_rx_overload,
    frame_lock: i_frame_lock,
    billing: i_billing_tone,
    dropout: i_supply_dropout,
    overcurrent: i_overcurrent,
    tip_gnd_status: i_tip_ground_status,
    lvs_msb: i_line_voltage_msb,
    loop_current: i_loop_current
  };

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    // line pins come from the isolated side: two stages before use
    next_st.sync1 = line_in;
    next_st.sync2 = st.sync1;
    ln = st.sync2;
    // polarity history is only trusted once the synchroniser is full
    next_st.warm = (st.warm == 2'h3) ? st.warm : st.warm + 2'h1;

    ring_hit = ln.ring_pos | (st.full_wave & ln.ring_neg);

    ring_now = st.ring_status;
    if (st.offhook)
    begin
      ring_now = 1'b0;
      next_st.ring_cnt = '0;
    end
    else if (ring_hit)
    begin
      ring_now = 1'b1;
      next_st.ring_cnt = HOLD;
    end
    else if (st.ring_cnt != '0)
    begin
      next_st.ring_cnt = st.ring_cnt - lefh_cnt_type'(1);
      ring_now = (st.ring_cnt != lefh_cnt_type'(1));
    end
    else
    begin
      ring_now = 1'b0;
    end
    next_st.ring_status = ring_now;
    next_st.ring_prev = st.ring_status;

    set_ev = '0;
    set_ev[`LEFH_EV_RING] = st.ring_status & ~st.ring_prev;
    // dual mode adds burst end; sticky flag hides it if uncleared
    if (st.ring_mode & ~st.ring_status & st.ring_prev)
    begin
      set_ev[`LEFH_EV_RING] = 1'b1;
    end
    set_ev[`LEFH_EV_RX_OVL] = ln.rx_ovl;
    set_ev[`LEFH_EV_FRAME] = ~ln.frame_lock;
    set_ev[`LEFH_EV_BILLING] = ln.billing;
    set_ev[`LEFH_EV_DROPOUT] = ln.dropout;
    set_ev[`LEFH_EV_LOOP_OVL] = (ln.loop_current == `LEFH_LOOP_MAX);
    set_ev[`LEFH_EV_TIP_GND] = ~ln.tip_gnd_status;
    set_ev[`LEFH_EV_POLARITY] = (st.warm == 2'h3) & (ln.lvs_msb != st.lvs_prev);
    next_st.lvs_prev = ln.lvs_msb;

    // flags register: write 0 clears, write 1 keeps; clear register: write 1 clears
    clr_ev = '0;
    if (i_wr && i_addr == `LEFH_OFS_EVENT_FLAGS)
    begin
      clr_ev = ~i_wdata;
    end
    else if (i_wr && i_addr == `LEFH_OFS_EVENT_CLEAR)
    begin
      clr_ev = i_wdata;
    end
    // set beats clear in the same cycle
    next_st.flags = (st.flags & ~clr_ev) | set_ev;

    if (i_wr)
    begin
      unique case (i_addr)
        `LEFH_OFS_INT_CTRL:
        begin
          next_st.global_interrupt_enable = i_wdata[`LEFH_BIT_GLOBAL_INTERRUPT_ENABLE];
          next_st.ring_mode = i_wdata[`LEFH_BIT_RING_MODE];
        end
        `LEFH_OFS_EVENT_MASK:
        begin
          next_st.mask = i_wdata;
        end
        `LEFH_OFS_HOOK_CTRL:
        begin
          next_st.onhook_mon = i_wdata[`LEFH_BIT_ONHOOK_MON];
          next_st.offhook = i_wdata[`LEFH_BIT_OFFHOOK];
        end
        `LEFH_OFS_POWER_CTRL:
        begin
          next_st.powerdown = i_wdata[`LEFH_BIT_POWERDOWN];
        end
        `LEFH_OFS_RING_OPT:
        begin
          next_st.full_wave = i_wdata[`LEFH_BIT_FULL_WAVE];
        end
        default:
        begin
        end
      endcase
    end

    rd_val = '0;
    unique case (i_addr)
      `LEFH_OFS_INT_CTRL:
      begin
        rd_val[`LEFH_BIT_GLOBAL_INTERRUPT_ENABLE] = st.global_interrupt_enable;
        rd_val[`LEFH_BIT_RING_MODE] = st.ring_mode;
      end
      `LEFH_OFS_EVENT_MASK:
      begin
        rd_val = st.mask;
      end
      `LEFH_OFS_EVENT_FLAGS:
      begin
        rd_val = st.flags;
      end
      `LEFH_OFS_HOOK_CTRL:
      begin
        rd_val[`LEFH_BIT_NEG_RING] = ln.ring_neg;
        rd_val[`LEFH_BIT_POS_RING] = ln.ring_pos;
        rd_val[`LEFH_BIT_ONHOOK_MON] = st.onhook_mon;
        rd_val[`LEFH_BIT_RING_STATUS] = st.ring_status;
        rd_val[`LEFH_BIT_OFFHOOK] = st.offhook;
      end
      `LEFH_OFS_POWER_CTRL:
      begin
        rd_val[`LEFH_BIT_POWERDOWN] = st.powerdown;
      end
      `LEFH_OFS_LINE_STATUS:
      begin
        rd_val[`LEFH_BIT_FRAME_LOCK] = ln.frame_lock;
        rd_val[4:0] = ln.loop_current;
      end
      `LEFH_OFS_RING_OPT:
      begin
        rd_val[`LEFH_BIT_FULL_WAVE] = st.full_wave;
      end
      `LEFH_OFS_RX_STATUS:
      begin
        // status is the flag itself, so one clear drops both
        rd_val[`LEFH_BIT_RX_OVL] = st.flags[`LEFH_EV_RX_OVL];
      end
      `LEFH_OFS_SUPPLY_STATUS:
      begin
        rd_val[`LEFH_BIT_DROPOUT] = ln.dropout;
        rd_val[`LEFH_BIT_OVERCURRENT] = ln.overcurrent;
      end
      default:
      begin
        rd_val = '0;
      end
    endcase
    next_st.rdata = i_rd ? rd_val : 8'h00;

    next_st.irq = st.global_interrupt_enable & (|(next_st.flags & st.mask));
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st <= '0;
      st.powerdown <= `LEFH_RST_POWERDOWN;
      // lock assumed present so reset does not fake a frame event
      st.sync1.frame_lock <= 1'b1;
      st.sync2.frame_lock <= 1'b1;
      st.sync1.tip_gnd_status <= 1'b1;
      st.sync2.tip_gnd_status <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_irq = st.irq;
  assign o_offhook = st.offhook;
  assign o_onhook_monitor = st.onhook_mon;
  assign o_line_powerdown = st.powerdown;

endmodule : lefh_line_event_flags
`default_nettype wire

// ---- dv/lefh_line_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module lefh_line_assertions (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_offhook,
  input wire logic o_onhook_monitor,
  input wire logic o_line_powerdown
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire w5 = i_wr && i_addr == 5'h05;
  ////////////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  reserved_read_a: assert property (i_rd && i_addr == 5'h05 |=> (o_rdata & 8'h92) == 8'h00)
    else $error("reserved hook bits set");
  hook_write_a: assert property (w5 |=> o_offhook == $past(i_wdata[0]))
    else $error("offhook not written");
  hook_hold_a: assert property (!w5 |=> $stable(o_offhook))
    else $error("offhook moved");
  monitor_write_a: assert property (w5 |=> o_onhook_monitor == $past(i_wdata[3]))
    else $error("monitor not written");
  pdl_write_a: assert property (i_wr && i_addr == 5'h06 |=> o_line_powerdown == $past(i_wdata[4]))
    else $error("powerdown not written");
  irq_gate_a: assert property (i_wr && i_addr == 5'h02 && !i_wdata[7] |-> ##2 !o_irq)
    else $error("irq without enable");
  irq_mask_a: assert property (i_wr && i_addr == 5'h03 && i_wdata == 8'h00 |-> ##2 !o_irq)
    else $error("irq without mask");
endmodule : lefh_line_assertions
bind lefh_line_event_flags lefh_line_assertions u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_irq(o_irq), .o_offhook(o_offhook), .o_onhook_monitor(o_onhook_monitor),
  .o_line_powerdown(o_line_powerdown));
`default_nettype wire

// ---- dv/lefh_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lefh_line_model
  import lefh_pkg::*;
(
  input wire logic i_clk,
  input wire logic [9:0] i_cmd,
  output lefh_line_type o_line
);
  // quiet line: locked, tip not grounded, modest loop current
  initial o_line = 14'h0443;
  // conditions move just after the edge, as an unrelated source would
  always @(posedge i_clk)
  begin
    o_line.ring_pos <= i_cmd[0];
    o_line.ring_neg <= i_cmd[1];
    o_line.rx_ovl <= i_cmd[2];
    o_line.frame_lock <= !i_cmd[3];
    o_line.billing <= i_cmd[4];
    o_line.dropout <= i_cmd[5];
    o_line.overcurrent <= i_cmd[6];
    o_line.tip_gnd_status <= !i_cmd[7];
    o_line.lvs_msb <= i_cmd[8];
    o_line.loop_current <= i_cmd[9] ? 5'h1f : 5'h03;
  end
endmodule : lefh_line_model
`default_nettype wire

// ---- dv/line_event_flags_and_hook_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module line_event_flags_and_hook_control_test import lefh_pkg::*;;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [9:0] cmd = 10'h000;
  lefh_line_type ln;
  logic [7:0] o_rdata;
  logic o_irq, o_offhook, o_onhook_monitor, o_line_powerdown;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // line command beside the flags it should leave
  logic [17:0] rows [10] = '{18'h00180, 18'h00200, 18'h00440, 18'h00820, 18'h01010,
    18'h02008, 18'h04000, 18'h08002, 18'h10001, 18'h20004};
  ////////////////////////////////////////////////////////////////////////
  always #20 i_clk = ~i_clk;
  lefh_line_model u_line (.i_clk(i_clk), .i_cmd(cmd), .o_line(ln));
  lefh_line_event_flags #(.RING_HOLD_CYCLES(50)) dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_ring_pos(ln.ring_pos), .i_ring_neg(ln.ring_neg), .i_rx_overload(ln.rx_ovl),
    .i_frame_lock(ln.frame_lock), .i_billing_tone(ln.billing),
    .i_supply_dropout(ln.dropout), .i_overcurrent(ln.overcurrent),
    .i_tip_ground_status(ln.tip_gnd_status), .i_line_voltage_msb(ln.lvs_msb),
    .i_loop_current(ln.loop_current), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_offhook(o_offhook), .o_onhook_monitor(o_onhook_monitor),
    .o_line_powerdown(o_line_powerdown));
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    // one idle edge so back-to-back writes never drive the strobe twice in one step
    @(posedge i_clk);
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rd
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      close_out();
    end
  end
  initial
  begin
    tick(3);
    i_arst_n <= 1'b1;
    chk({6'h0, o_line_powerdown, o_offhook}, 8'h02);
    wr(5'h06, 8'h00);
    wr(5'h04, 8'h00);
    wr(5'h03, 8'hff);
    wr(5'h02, 8'h80);
    foreach (rows[k])
    begin
      cmd <= rows[k][17:8];
      tick(4);
      cmd <= 10'h000;
      tick(8);
      rd(5'h04, rows[k][7:0]);
      chk({7'h0, o_irq}, {7'h0, |rows[k][7:0]});
      wr(5'h04, 8'hff);
      rd(5'h04, rows[k][7:0]);
      wr(5'h04, 8'h00);
      rd(5'h04, 8'h00);
    end
    // overcurrent is read live beside the overload flag; rx status mirrors flag
    cmd <= 10'h044;
    tick(6);
    rd(5'h13, 8'h01);
    cmd <= 10'h000;
    tick(6);
    rd(5'h11, 8'h01);
    wr(5'h04, 8'hbf);
    rd(5'h11, 8'h00);
    // full-wave ring in dual burst mode, start event cleared in mid-burst
    wr(5'h10, 8'h01);
    wr(5'h02, 8'h84);
    cmd <= 10'h002;
    tick(6);
    rd(5'h05, 8'h44);
    wr(5'h04, 8'h00);
    cmd <= 10'h000;
    tick(70);
    rd(5'h04, 8'h80);
    wr(5'h03, 8'h00);
    tick(2);
    #1 chk({7'h0, o_irq}, 8'h00);
    wr(5'h04, 8'h00);
    // off-hook holds ring status low while a ring runs
    wr(5'h05, 8'h09);
    cmd <= 10'h001;
    tick(6);
    rd(5'h05, 8'h29);
    wr(5'h05, 8'h00);
    tick(4);
    rd(5'h05, 8'h24);
    cmd <= 10'h000;
    tick(40);
    rd(5'h05, 8'h04);
    tick(20);
    rd(5'h05, 8'h00);
    rd(5'h1f, 8'h00);
    wr(5'h02, 8'h00);
    tick(2);
    close_out();
  end
endmodule : line_event_flags_and_hook_control_test
`default_nettype wire
